// >>> logic/slr_defines.svh
`ifndef SLR_DEFINES_SVH
`define SLR_DEFINES_SVH

`define SLR_OFF_CTRL        8'h00
`define SLR_OFF_STATUS      8'h04
`define SLR_OFF_DATA        8'h08
`define SLR_OFF_IRQ_STAT    8'h0C
`define SLR_OFF_IRQ_MASK    8'h10

`define SLR_CTRL_REFRAME    0
`define SLR_CTRL_INSEL      1
`define SLR_CTRL_BISTN      2
`define SLR_CTRL_MODE       3
`define SLR_CTRL_RESET      5'h06

`define SLR_STAT_DOUBLE     0
`define SLR_STAT_BIST_RUN   1
`define SLR_STAT_BIST_WAIT  2
`define SLR_STAT_STATUS_IN  3

`define SLR_IRQ_BYTE        0
`define SLR_IRQ_VIOL        1
`define SLR_IRQ_REFRAME     2
`define SLR_IRQ_DOUBLE      3
`define SLR_IRQ_LOOP        4
`define SLR_IRQ_W           5

`define SLR_BITS_PER_BYTE   4'hA
`define SLR_CLK_FALL_BIT    4'h4
`define SLR_DOUBLE_BYTES    2048
`define SLR_BIST_LAST       9'h1FE
`define SLR_BIST_SEED       9'h100
`define SLR_COMMA_NEG       10'h0FA
`define SLR_COMMA_POS       10'h305
`define SLR_NULL_BYTE       8'hBC

`endif

// >>> logic/slr_deframer.sv
`timescale 1ns/1ns
`default_nettype none
`include "slr_defines.svh"

module slr_deframer
    import slr_pkg::*;
#(
    parameter int DOUBLE_BYTES = `SLR_DOUBLE_BYTES
) (
    input  wire logic        pclk,                 // APB and bit clock
    input  wire logic        presetn,              // Async reset, low
    input  wire logic [7:0]  paddr,                // APB byte address
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB access phase
    input  wire logic        pwrite,               // APB write
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error
    input  wire logic        serial_in_primary,    // Serial input A
    input  wire logic        serial_in_secondary,  // Serial input B
    input  wire logic        status_in,            // Status monitor input
    output logic             status_out,           // Status monitor copy
    output logic      [7:0]  rx_parallel_byte,     // Received byte
    output logic             special_char_flag,    // Control code flag
    output logic             code_violation_flag,  // Violation flag
    output logic             ready_n,              // Byte ready, low
    output logic             recovered_byte_clock, // Byte rate clock
    output logic             irq                   // Interrupt, high
);

    localparam int CW = $clog2(DOUBLE_BYTES + 1);

    if (DOUBLE_BYTES < 2 || DOUBLE_BYTES > 65535) begin
        $error("DOUBLE_BYTES out of range");
    end

    // Returns {valid, EDCBA} for a six-bit group abcdei.
    function automatic logic [5:0] dec6(input logic [5:0] s);
        logic [5:0] r;
        r = 6'h00;
        unique case (s)
            6'b100111, 6'b011000: r = {1'b1, 5'd0};
            6'b011101, 6'b100010: r = {1'b1, 5'd1};
            6'b101101, 6'b010010: r = {1'b1, 5'd2};
            6'b110001:            r = {1'b1, 5'd3};
            6'b110101, 6'b001010: r = {1'b1, 5'd4};
            6'b101001:            r = {1'b1, 5'd5};
            6'b011001:            r = {1'b1, 5'd6};
            6'b111000, 6'b000111: r = {1'b1, 5'd7};
            6'b111001, 6'b000110: r = {1'b1, 5'd8};
            6'b100101:            r = {1'b1, 5'd9};
            6'b010101:            r = {1'b1, 5'd10};
            6'b110100:            r = {1'b1, 5'd11};
            6'b001101:            r = {1'b1, 5'd12};
            6'b101100:            r = {1'b1, 5'd13};
            6'b011100:            r = {1'b1, 5'd14};
            6'b010111, 6'b101000: r = {1'b1, 5'd15};
            6'b011011, 6'b100100: r = {1'b1, 5'd16};
            6'b100011:            r = {1'b1, 5'd17};
            6'b010011:            r = {1'b1, 5'd18};
            6'b110010:            r = {1'b1, 5'd19};
            6'b001011:            r = {1'b1, 5'd20};
            6'b101010:            r = {1'b1, 5'd21};
            6'b011010:            r = {1'b1, 5'd22};
            6'b111010, 6'b000101: r = {1'b1, 5'd23};
            6'b110011, 6'b001100: r = {1'b1, 5'd24};
            6'b100110:            r = {1'b1, 5'd25};
            6'b010110:            r = {1'b1, 5'd26};
            6'b110110, 6'b001001: r = {1'b1, 5'd27};
            6'b001110:            r = {1'b1, 5'd28};
            6'b101110, 6'b010001: r = {1'b1, 5'd29};
            6'b011110, 6'b100001: r = {1'b1, 5'd30};
            6'b101011, 6'b010100: r = {1'b1, 5'd31};
            6'b001111, 6'b110000: r = {1'b1, 5'd28};
            default:              r = 6'h00;
        endcase
        return r;
    endfunction

    // Returns {valid, HGF} for a four-bit group fghj.
    function automatic logic [3:0] dec4(input logic [3:0] s);
        logic [3:0] r;
        r = 4'h0;
        unique case (s)
            4'b1011, 4'b0100:                   r = {1'b1, 3'd0};
            4'b1001:                            r = {1'b1, 3'd1};
            4'b0101:                            r = {1'b1, 3'd2};
            4'b1100, 4'b0011:                   r = {1'b1, 3'd3};
            4'b1101, 4'b0010:                   r = {1'b1, 3'd4};
            4'b1010:                            r = {1'b1, 3'd5};
            4'b0110:                            r = {1'b1, 3'd6};
            4'b1110, 4'b0001, 4'b0111, 4'b1000: r = {1'b1, 3'd7};
            default:                            r = 4'h0;
        endcase
        return r;
    endfunction

    slr_ctrl_s    ctrl;
    slr_bist_e    bist_state;
    slr_rx_word_s dec_word;
    slr_rx_word_s raw_word;
    slr_rx_word_s next_word;

    logic [9:0]          shifter;
    logic [9:0]          next_shift;
    logic [3:0]          bit_cnt;
    logic [3:0]          since_comma;
    logic [CW-1:0]       byte_cnt;
    logic                double_byte;
    logic                tck_q;
    logic                bit_en;
    logic                serial_bit;
    logic                comma_now;
    logic                reframe_hit;
    logic                byte_done;
    logic                is_null;
    logic [8:0]          lfsr;
    logic [8:0]          loop_pos;
    logic                bist_last;
    logic [5:0]          d6;
    logic [3:0]          d4;
    logic                k28;
    logic                kx7;
    logic [`SLR_IRQ_W-1:0] irq_stat;
    logic [`SLR_IRQ_W-1:0] irq_mask;
    logic [`SLR_IRQ_W-1:0] events;
    logic                apb_take;
    logic                apb_fire;
    logic                wr_fire;
    logic                dbl_enter;

    // In test mode the secondary input is a bit clock; its rising edge
    // clocks one bit, so the primary input carries the data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_q <= 1'b0;
        end else begin
            tck_q <= serial_in_secondary;
        end
    end

    always_comb begin
        if (ctrl.mode == SLR_MODE_TEST) begin
            bit_en     = serial_in_secondary & ~tck_q;
            serial_bit = serial_in_primary;
        end else begin
            bit_en     = 1'b1;
            serial_bit = ctrl.input_sel ? serial_in_primary
                                        : serial_in_secondary;
        end
    end

    assign next_shift = {shifter[8:0], serial_bit};
    assign comma_now  = (next_shift == `SLR_COMMA_NEG) ||
                        (next_shift == `SLR_COMMA_POS);
    // Two commas exactly one byte apart are needed once framing is trusted.
    assign reframe_hit = ctrl.reframe_enable & comma_now &
                         (~double_byte | (since_comma == 4'h9));
    // With reframing off only the free-running counter closes a byte.
    assign byte_done = bit_en & ((bit_cnt == `SLR_BITS_PER_BYTE - 4'h1) |
                                 reframe_hit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shifter     <= 10'h000;
            bit_cnt     <= 4'h0;
            since_comma <= 4'hF;
        end else if (bit_en) begin
            shifter     <= next_shift;
            bit_cnt     <= byte_done ? 4'h0 : bit_cnt + 4'h1;
            if (comma_now) begin
                since_comma <= 4'h0;
            end else if (since_comma != 4'hF) begin
                since_comma <= since_comma + 4'h1;
            end
        end
    end

    assign dbl_enter = byte_done & ctrl.reframe_enable & ~double_byte &
                       (byte_cnt == CW'(DOUBLE_BYTES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_cnt    <= '0;
            double_byte <= 1'b0;
        end else if (!ctrl.reframe_enable) begin
            byte_cnt    <= '0;
            double_byte <= 1'b0;
        end else if (byte_done && !double_byte) begin
            byte_cnt    <= byte_cnt + CW'(1);
            double_byte <= dbl_enter;
        end
    end

    // Running disparity is not tracked; only invalid groups count as errors.
    always_comb begin
        d6  = dec6(next_shift[9:4]);
        k28 = (next_shift[9:4] == 6'b001111) ||
              (next_shift[9:4] == 6'b110000);
        d4  = dec4((next_shift[9:4] == 6'b110000) ? ~next_shift[3:0]
                                                   : next_shift[3:0]);
        kx7 = ((next_shift[3:0] == 4'b0111) ||
               (next_shift[3:0] == 4'b1000)) &&
              ((d6[4:0] == 5'd23) || (d6[4:0] == 5'd27) ||
               (d6[4:0] == 5'd29) || (d6[4:0] == 5'd30));
        dec_word.data = {d4[2:0], d6[4:0]};
        dec_word.sc   = k28 | kx7;
        dec_word.viol = ~d6[5] | ~d4[3];
    end

    always_comb begin
        raw_word.sc   = next_shift[9];
        raw_word.viol = next_shift[0];
        for (int i = 0; i < 8; i++) begin
            raw_word.data[i] = next_shift[8-i];
        end
    end

    assign bist_last = (bist_state == SLR_BIST_RUN) &&
                       (loop_pos == `SLR_BIST_LAST);

    always_comb begin
        next_word = (ctrl.mode == SLR_MODE_BYPASS) ? raw_word : dec_word;
        is_null   = (ctrl.mode == SLR_MODE_BYPASS) ? comma_now :
                    (dec_word.sc && !dec_word.viol &&
                     dec_word.data == `SLR_NULL_BYTE);
        if (bist_state == SLR_BIST_RUN) begin
            next_word.viol = dec_word.sc ||
                             (dec_word.data != lfsr[7:0]);
        end
    end

    // Self-test: a nine-bit LFSR seeded so its first byte is D0.0.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bist_state <= SLR_BIST_OFF;
            lfsr       <= `SLR_BIST_SEED;
            loop_pos   <= 9'h000;
        end else if (ctrl.self_test_enable_n ||
                     ctrl.mode != SLR_MODE_DECODE) begin
            bist_state <= SLR_BIST_OFF;
        end else begin
            unique case (bist_state)
                SLR_BIST_OFF: begin
                    bist_state <= SLR_BIST_WAIT;
                end
                SLR_BIST_WAIT: begin
                    if (byte_done && !dec_word.sc && !dec_word.viol &&
                        dec_word.data == 8'h00) begin
                        bist_state <= SLR_BIST_RUN;
                        lfsr       <= 9'({`SLR_BIST_SEED,
                                          `SLR_BIST_SEED} >> 8);
                        loop_pos   <= 9'h001;
                    end
                end
                SLR_BIST_RUN: begin
                    if (byte_done) begin
                        lfsr     <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
                        loop_pos <= bist_last ? 9'h000 : loop_pos + 9'h001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_parallel_byte     <= 8'h00;
            special_char_flag    <= 1'b0;
            code_violation_flag  <= 1'b0;
            ready_n              <= 1'b1;
            recovered_byte_clock <= 1'b0;
        end else if (byte_done && !recovered_byte_clock) begin
            rx_parallel_byte     <= next_word.data;
            special_char_flag    <= next_word.sc;
            code_violation_flag  <= next_word.viol;
            recovered_byte_clock <= 1'b1;
            if (bist_state == SLR_BIST_RUN) begin
                ready_n <= ~bist_last;
            end else begin
                ready_n <= is_null;
            end
        end else if (bit_en && (byte_done ||
                                bit_cnt == `SLR_CLK_FALL_BIT)) begin
            // Dropping a comma that lands while high gives each load its edge.
            recovered_byte_clock <= 1'b0;
            if (bist_state != SLR_BIST_RUN) begin
                ready_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out <= 1'b0;
        end else begin
            status_out <= status_in;
        end
    end

    always_comb begin
        events = '0;
        events[`SLR_IRQ_BYTE]    = byte_done & ~is_null;
        events[`SLR_IRQ_VIOL]    = byte_done & next_word.viol &
                                   (ctrl.mode != SLR_MODE_BYPASS);
        events[`SLR_IRQ_REFRAME] = reframe_hit &
                                   (bit_cnt != `SLR_BITS_PER_BYTE - 4'h1);
        events[`SLR_IRQ_DOUBLE]  = dbl_enter;
        events[`SLR_IRQ_LOOP]    = byte_done & bist_last;
    end

    // A one-wait-state slave: pready rises on the second access cycle.
    assign apb_take = psel & penable & ~pready;
    assign apb_fire = psel & penable & pready;
    assign wr_fire  = apb_fire & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_take;
            pslverr <= 1'b0;
            if (apb_take) begin
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    `SLR_OFF_CTRL:     prdata[4:0] <= ctrl;
                    `SLR_OFF_STATUS: begin
                        prdata[`SLR_STAT_DOUBLE]    <= double_byte;
                        prdata[`SLR_STAT_BIST_RUN]  <=
                            (bist_state == SLR_BIST_RUN);
                        prdata[`SLR_STAT_BIST_WAIT] <=
                            (bist_state == SLR_BIST_WAIT);
                        prdata[`SLR_STAT_STATUS_IN] <= status_out;
                    end
                    `SLR_OFF_DATA: begin
                        prdata[9:0] <= {code_violation_flag,
                                        special_char_flag,
                                        rx_parallel_byte};
                    end
                    `SLR_OFF_IRQ_STAT: prdata[`SLR_IRQ_W-1:0] <= irq_stat;
                    `SLR_OFF_IRQ_MASK: prdata[`SLR_IRQ_W-1:0] <= irq_mask;
                    default:           pslverr <= 1'b1;
                endcase
            end
        end
    end

    // The reserved mode code is refused so the decoder never sees it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SLR_CTRL_RESET;
        end else if (wr_fire && paddr == `SLR_OFF_CTRL) begin
            ctrl.reframe_enable     <= pwdata[`SLR_CTRL_REFRAME];
            ctrl.input_sel          <= pwdata[`SLR_CTRL_INSEL];
            ctrl.self_test_enable_n <= pwdata[`SLR_CTRL_BISTN];
            if (pwdata[`SLR_CTRL_MODE+1:`SLR_CTRL_MODE] != 2'b10) begin
                ctrl.mode <= slr_mode_e'(
                    pwdata[`SLR_CTRL_MODE+1:`SLR_CTRL_MODE]);
            end
        end
    end

    // An event in the cycle of its write-one-to-clear still sets the bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq      <= 1'b0;
        end else begin
            if (wr_fire && paddr == `SLR_OFF_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[`SLR_IRQ_W-1:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
            if (wr_fire && paddr == `SLR_OFF_IRQ_MASK) begin
                irq_mask <= pwdata[`SLR_IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

endmodule
`default_nettype wire

// >>> logic/slr_pkg.sv
package slr_pkg;

    typedef enum logic [1:0] {
        SLR_MODE_DECODE = 2'b00,
        SLR_MODE_BYPASS = 2'b01,
        SLR_MODE_TEST   = 2'b11
    } slr_mode_e;

    typedef enum logic [1:0] {
        SLR_BIST_OFF  = 2'b00,
        SLR_BIST_WAIT = 2'b01,
        SLR_BIST_RUN  = 2'b11
    } slr_bist_e;

    typedef struct packed {
        slr_mode_e mode;
        logic      self_test_enable_n;
        logic      input_sel;
        logic      reframe_enable;
    } slr_ctrl_s;

    typedef struct packed {
        logic       viol;
        logic       sc;
        logic [7:0] data;
    } slr_rx_word_s;

endpackage

// >>> verification/serial_link_receiver_deframer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "slr_defines.svh"
module serial_link_receiver_deframer_bench import slr_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic serial_in_primary = 0, serial_in_secondary = 0, status_in = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, status_out, special_char_flag, er, sel_a = 1;
    logic code_violation_flag, ready_n, recovered_byte_clock, irq;
    logic [7:0] rx_parallel_byte;
    logic bq[$];
    logic [10:0] eq[$], mq[$];
    int error_cnt = 0, n_tests = 0;
    initial forever #5 pclk = ~pclk;
    slr_deframer #(.DOUBLE_BYTES(8)) u_dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in_primary(serial_in_primary), .status_in(status_in),
        .serial_in_secondary(serial_in_secondary), .status_out(status_out),
        .rx_parallel_byte(rx_parallel_byte), .ready_n(ready_n),
        .special_char_flag(special_char_flag), .irq(irq),
        .code_violation_flag(code_violation_flag),
        .recovered_byte_clock(recovered_byte_clock));
    slr_rx_sink u_sink (.pclk(pclk), .presetn(presetn), .ready_n(ready_n),
        .recovered_byte_clock(recovered_byte_clock),
        .code_violation_flag(code_violation_flag),
        .special_char_flag(special_char_flag),
        .rx_parallel_byte(rx_parallel_byte));
    // Idle fill is whole commas, so queued symbols keep their alignment; the
    // unused input toggles at random so a wrong input choice shows up.
    always @(posedge pclk) begin
        logic b;
        if (bq.size() == 0)
            for (int i = 9; i >= 0; i--)
                bq.push_back(1'(`SLR_COMMA_NEG >> i));
        b = bq.pop_front();
        serial_in_primary <= sel_a ? b : 1'($urandom);
        serial_in_secondary <= sel_a ? 1'($urandom) : b;
        status_in <= 1'($urandom);
    end
    task automatic end_sim();
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error %0t %s", $time, m);
        end
    endtask
    task automatic fail(input string m);
        chk(1'b0, m);
        end_sim();
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            fail("apb timeout");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] ctrl(slr_mode_e m, logic s, logic r);
        slr_ctrl_s c;
        c = '{mode: m, self_test_enable_n: 1'b1, input_sel: s,
              reframe_enable: r};
        return {27'h0, c};
    endfunction
    function automatic logic [10:0] byp(logic [9:0] w);
        logic [10:0] v;
        v = {1'b0, w[0], w[9], 8'h00};
        for (int k = 1; k <= 8; k++)
            v[k-1] = w[9-k];
        return v;
    endfunction
    task automatic sx(input logic [9:0] s, input logic [10:0] v, m);
        for (int i = 9; i >= 0; i--)
            bq.push_back(s[i]);
        eq.push_back(v);
        mq.push_back(m);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (bq.size() > 10 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000)
            fail("stream stuck");
        repeat (40) @(posedge pclk);
    endtask
    // The first expected word marks where the sequence starts in the capture.
    task automatic check_seq(input string m);
        int i;
        i = 0;
        while (i < u_sink.q.size() && ((u_sink.q[i] ^ eq[0]) & mq[0]) != 0)
            i++;
        for (int k = 0; k < eq.size(); k++)
            chk(i + k < u_sink.q.size() &&
                ((u_sink.q[i+k] ^ eq[k]) & mq[k]) === 11'h000, m);
        eq.delete();
        mq.delete();
    endtask
    initial begin
        logic [9:0] w;
        void'($urandom(30564));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `SLR_OFF_CTRL, 32'h0);
        chk(rd === 32'h6, "ctrl reset value");
        apb(1'b0, 8'h14, 32'h0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped access");
        apb(1'b1, `SLR_OFF_CTRL, ctrl(SLR_MODE_DECODE, 1'b1, 1'b1));
        repeat (30) @(posedge pclk);
        apb(1'b0, `SLR_OFF_STATUS, 32'h0);
        chk(rd[0] === 1'b0, "double mode too early");
        repeat (100) @(posedge pclk);
        apb(1'b0, `SLR_OFF_STATUS, 32'h0);
        chk(rd[0] === 1'b1, "double mode missing");
        chk(irq === 1'b0, "masked interrupt raised");
        apb(1'b1, `SLR_OFF_IRQ_MASK, 32'h8);
        repeat (2) @(posedge pclk);
        chk(irq === 1'b1, "interrupt missing");
        apb(1'b1, `SLR_OFF_IRQ_STAT, 32'h8);
        repeat (2) @(posedge pclk);
        chk(irq === 1'b0, "interrupt not cleared");
        apb(1'b0, `SLR_OFF_IRQ_STAT, 32'h0);
        chk(rd[3] === 1'b0, "status bit not cleared");
        apb(1'b1, `SLR_OFF_CTRL, ctrl(SLR_MODE_DECODE, 1'b1, 1'b0));
        repeat (3) bq.push_back(1'b0);
        repeat (20) @(posedge pclk);
        u_sink.q.delete();
        repeat (120) @(posedge pclk);
        chk(u_sink.q.size() >= 10, "counter framing stopped");
        foreach (u_sink.q[i])
            chk(u_sink.q[i][8:0] !== 9'h1BC, "reframed while off");
        for (int s = 1; s >= 0; s--) begin
            sel_a <= s[0];
            apb(1'b1, `SLR_OFF_CTRL, ctrl(SLR_MODE_DECODE, s[0], 1'b1));
            repeat (40) @(posedge pclk);
            u_sink.q.delete();
            sx(10'h274, 11'h000, 11'h7FF);
            sx(10'h2AA, 11'h0B5, 11'h7FF);
            sx(`SLR_COMMA_NEG, 11'h5BC, 11'h7FF);
            sx(10'h274, 11'h000, 11'h7FF);
            sx(10'h000, 11'h200, 11'h200);
            drain();
            check_seq("decoded stream");
        end
        sel_a <= 1'b1;
        apb(1'b1, `SLR_OFF_CTRL, ctrl(SLR_MODE_BYPASS, 1'b1, 1'b1));
        repeat (30) @(posedge pclk);
        u_sink.q.delete();
        sx(10'h3FF, byp(10'h3FF), 11'h3FF);
        repeat (8) begin
            w = 10'($urandom);
            sx(w, byp(w), 11'h3FF);
        end
        drain();
        check_seq("bypass stream");
        apb(1'b1, `SLR_OFF_CTRL, 32'h2);
        apb(1'b0, `SLR_OFF_STATUS, 32'h0);
        chk(rd[2:1] === 2'b10, "self-test not waiting");
        end_sim();
    end
endmodule
`default_nettype wire

// >>> verification/slr_deframer_checker.sv
`timescale 1ns/1ns
`default_nettype none
module slr_deframer_checker (
    input wire logic       pclk,                 // Clock
    input wire logic       presetn,              // Reset, low
    input wire logic       psel,                 // APB select
    input wire logic       penable,              // APB access
    input wire logic       pready,               // APB ready
    input wire logic       pslverr,              // APB error
    input wire logic       status_in,            // Status input
    input wire logic       status_out,           // Status output
    input wire logic [7:0] rx_parallel_byte,     // Byte out
    input wire logic       special_char_flag,    // Control flag
    input wire logic       code_violation_flag,  // Violation flag
    input wire logic       ready_n,              // Ready, low
    input wire logic       recovered_byte_clock  // Byte clock
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_apb_wait;
        s_access |=> s_answer;
    endproperty
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    property p_byte_hold;
        !$stable(rx_parallel_byte) |-> $rose(recovered_byte_clock);
    endproperty
    property p_sc_hold;
        !$stable(special_char_flag) |-> $rose(recovered_byte_clock);
    endproperty
    property p_viol_hold;
        !$stable(code_violation_flag) |-> $rose(recovered_byte_clock);
    endproperty
    property p_ready_edge;
        $fell(ready_n) |-> $rose(recovered_byte_clock);
    endproperty
    // The high phase shrinks after a reframe, so only a bound is checked.
    property p_clk_high;
        $rose(recovered_byte_clock) |-> ##[1:6] !recovered_byte_clock;
    endproperty
    property p_status;
        1'b1 |=> status_out == $past(status_in);
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("pready not a single cycle after access");
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr outside the answer cycle");
    a_byte_hold: assert property (p_byte_hold)
        else $error("byte changed off the byte clock edge");
    a_sc_hold: assert property (p_sc_hold)
        else $error("control flag changed off the byte clock edge");
    a_viol_hold: assert property (p_viol_hold)
        else $error("violation flag changed off the byte clock edge");
    a_ready_edge: assert property (p_ready_edge)
        else $error("ready fell off the byte clock edge");
    a_clk_high: assert property (p_clk_high)
        else $error("byte clock stuck high");
    a_status: assert property (p_status)
        else $error("status output does not follow its input");
endmodule
bind slr_deframer slr_deframer_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .status_in(status_in),
    .status_out(status_out), .rx_parallel_byte(rx_parallel_byte),
    .special_char_flag(special_char_flag), .ready_n(ready_n),
    .code_violation_flag(code_violation_flag),
    .recovered_byte_clock(recovered_byte_clock));
`default_nettype wire

// >>> verification/slr_rx_sink.sv
`timescale 1ns/1ns
`default_nettype none
module slr_rx_sink (
    input wire logic       pclk,                 // Bit clock
    input wire logic       presetn,              // Reset, low
    input wire logic       recovered_byte_clock, // Byte clock
    input wire logic       ready_n,              // Ready, low
    input wire logic       code_violation_flag,  // Violation flag
    input wire logic       special_char_flag,    // Control flag
    input wire logic [7:0] rx_parallel_byte      // Byte
);
    // A byte is taken one bit time after the byte clock rose, since on that
    // edge itself the outputs are still being updated.
    logic        last_clk;
    logic [10:0] q[$];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            last_clk <= 1'b0;
        else begin
            last_clk <= recovered_byte_clock;
            if (recovered_byte_clock && !last_clk)
                q.push_back({ready_n, code_violation_flag,
                             special_char_flag, rx_parallel_byte});
        end
    end
endmodule
`default_nettype wire
